/* File: rtl/dct_quant_rle_encoder.v */
// Residual coder: 8x8 block DCT, weighted quantizer, zigzag run/level output.
// Assumes one clock, samples and symbols on valid/ready, weights loaded by port.
//
// What this block does
// - Buffers and codes each 8x8 block alone.
// - Row transform first, then column transform.
// - Weights each coefficient, then rounds uniformly.
// - Weight matrix is writable through a port.
// - Reads coefficients out in zigzag order.
// - Emits zero run before each nonzero level.
// - Emits end marker once only zeros remain.
// - Run and level on separate fields together.
// - Intra and inter blocks take identical path.
`timescale 1ns/1ps
`default_nettype none
`include "dct_quant_rle_defines.vh"

module dct_quant_rle_encoder (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    output reg in_ready,
    input wire signed [8:0] in_sample,
    input wire in_intra,
    input wire wt_wr,
    input wire [5:0] wt_addr,
    input wire [7:0] wt_data,
    output reg out_valid,
    input wire out_ready,
    output reg [5:0] out_run,
    output reg signed [12:0] out_level,
    output reg block_end_marker,
    output reg out_intra
);

    reg [2:0] state_r;
    reg [5:0] cnt_r;
    reg [2:0] k_r;
    reg signed [24:0] acc_r;
    reg intra_r;
    reg [2:0] zr_r;
    reg [2:0] zc_r;
    reg [5:0] run_r;
    reg signed [8:0] smp_r [0:63];
    reg signed [13:0] row_r [0:63];
    reg signed [12:0] q_r [0:63];
    reg [7:0] wt_r [0:63];
    reg signed [13:0] opnd;
    reg [2:0] cf;
    reg [2:0] zr_nxt;
    reg [2:0] zc_nxt;
    wire signed [7:0] cos_c;
    wire signed [21:0] prod;
    wire signed [24:0] sum;
    wire signed [13:0] pass_res;
    wire signed [22:0] qp;
    wire [22:0] qmag;
    wire [22:0] qrnd;
    wire [12:0] qabs;
    wire [12:0] qlev;
    wire signed [12:0] scan_val;
    wire out_free;
    integer i;

    // Operand select for the shared multiply-accumulate
    always @*
    begin
        if (state_r == `ST_ROW)
        begin
            opnd = {{5{smp_r[{cnt_r[5:3], k_r}][8]}}, smp_r[{cnt_r[5:3], k_r}]};
            cf = cnt_r[2:0];
        end
        else
        begin
            opnd = row_r[{k_r, cnt_r[2:0]}];
            cf = cnt_r[5:3];
        end
    end

    dct_cos_coef u_cos (
        .freq(cf),
        .pos(k_r),
        .coef(cos_c)
    );

    assign prod = opnd * cos_c;
    assign sum = acc_r + {{3{prod[21]}}, prod};
    assign pass_res = sum[20:7];

    // Weighted quantizer, round to nearest, half away from zero
    assign qp = pass_res * $signed({1'b0, wt_r[cnt_r]});
    assign qmag = qp[22] ? (23'h000000 - qp) : qp;
    assign qrnd = qmag + `Q_HALF;
    assign qabs = qrnd[20:8];
    assign qlev = qp[22] ? (13'h0000 - qabs) : qabs;

    // Zigzag walker over (row, column)
    always @*
    begin
        zr_nxt = zr_r;
        zc_nxt = zc_r;
        if ((zr_r[0] ^ zc_r[0]) == 1'b0)
        begin
            if (zc_r == `LINE_LAST)
                zr_nxt = zr_r + 3'h1;
            else if (zr_r == 3'h0)
                zc_nxt = zc_r + 3'h1;
            else
            begin
                zr_nxt = zr_r - 3'h1;
                zc_nxt = zc_r + 3'h1;
            end
        end
        else
        begin
            if (zr_r == `LINE_LAST)
                zc_nxt = zc_r + 3'h1;
            else if (zc_r == 3'h0)
                zr_nxt = zr_r + 3'h1;
            else
            begin
                zr_nxt = zr_r + 3'h1;
                zc_nxt = zc_r - 3'h1;
            end
        end
    end

    assign scan_val = q_r[{zr_r, zc_r}];
    assign out_free = ~out_valid | out_ready;

    // Port-writable weight matrix
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < 64; i = i + 1)
                wt_r[i] <= `WT_RESET;
        end
        else if (wt_wr)
            wt_r[wt_addr] <= wt_data;
    end

    // Block storage, no reset needed
    always @(posedge clk)
    begin
        if (state_r == `ST_LOAD && in_ready && in_valid)
            smp_r[cnt_r] <= in_sample;
        if (state_r == `ST_ROW && k_r == `LINE_LAST)
            row_r[cnt_r] <= pass_res;
        if (state_r == `ST_COL && k_r == `LINE_LAST)
            q_r[cnt_r] <= qlev;
    end

    // Sequencer and output symbols
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= `ST_LOAD;
            cnt_r <= 6'h00;
            k_r <= 3'h0;
            acc_r <= 25'h0;
            intra_r <= 1'b0;
            zr_r <= 3'h0;
            zc_r <= 3'h0;
            run_r <= 6'h00;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
            out_run <= 6'h00;
            out_level <= 13'h0000;
            block_end_marker <= 1'b0;
            out_intra <= 1'b0;
        end
        else
        begin
            case (state_r)
                `ST_LOAD:
                begin
                    if (in_valid && in_ready)
                    begin
                        if (cnt_r == 6'h00)
                            intra_r <= in_intra;
                        cnt_r <= cnt_r + 6'h01;
                        if (cnt_r == `BLK_LAST)
                        begin
                            in_ready <= 1'b0;
                            state_r <= `ST_ROW;
                        end
                    end
                end
                `ST_ROW, `ST_COL:
                begin
                    k_r <= k_r + 3'h1;
                    if (k_r == `LINE_LAST)
                    begin
                        acc_r <= 25'h0;
                        cnt_r <= cnt_r + 6'h01;
                        if (cnt_r == `BLK_LAST)
                        begin
                            state_r <= (state_r == `ST_ROW) ? `ST_COL : `ST_SCAN;
                            zr_r <= 3'h0;
                            zc_r <= 3'h0;
                            run_r <= 6'h00;
                        end
                    end
                    else
                        acc_r <= sum;
                end
                `ST_SCAN:
                begin
                    if (out_free)
                    begin
                        out_valid <= 1'b0;
                        if (scan_val != 13'h0000)
                        begin
                            out_valid <= 1'b1;
                            out_run <= run_r;
                            out_level <= scan_val;
                            block_end_marker <= 1'b0;
                            out_intra <= intra_r;
                            run_r <= 6'h00;
                        end
                        else
                            run_r <= run_r + 6'h01;
                        zr_r <= zr_nxt;
                        zc_r <= zc_nxt;
                        cnt_r <= cnt_r + 6'h01;
                        if (cnt_r == `BLK_LAST)
                            state_r <= `ST_MARK;
                    end
                end
                `ST_MARK:
                begin
                    if (out_free)
                    begin
                        out_valid <= 1'b1;
                        block_end_marker <= 1'b1;
                        out_run <= 6'h00;
                        out_level <= 13'h0000;
                        out_intra <= intra_r;
                        state_r <= `ST_WAIT;
                    end
                end
                `ST_WAIT:
                begin
                    if (out_ready)
                    begin
                        out_valid <= 1'b0;
                        block_end_marker <= 1'b0;
                        in_ready <= 1'b1;
                        state_r <= `ST_LOAD;
                    end
                end
                default:
                begin
                    state_r <= `ST_LOAD;
                    in_ready <= 1'b1;
                    out_valid <= 1'b0;
                    cnt_r <= 6'h00;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: rtl/dct_quant_rle_defines.vh */
// Constants for the block transform, quantizer and run/level coder.
// Included by the coder and its cosine table; definitions only.
`ifndef DCT_QUANT_RLE_DEFINES_VH
`define DCT_QUANT_RLE_DEFINES_VH

// Block geometry
`define BLK_LAST 6'h3F
`define LINE_LAST 3'h7

// States
`define ST_LOAD 3'h0
`define ST_ROW 3'h1
`define ST_COL 3'h2
`define ST_SCAN 3'h3
`define ST_MARK 3'h4
`define ST_WAIT 3'h5

// Transform scaling: cosines carry a gain of 64, each pass drops 7 bits
`define PASS_SHIFT 7
`define COS_DC 7'h2D
`define COS_K0 7'h40
`define COS_K1 7'h3F
`define COS_K2 7'h3B
`define COS_K3 7'h35
`define COS_K4 7'h2D
`define COS_K5 7'h24
`define COS_K6 7'h18
`define COS_K7 7'h0C

// Quantizer: weight is a step reciprocal, product rounded then shifted by 8
`define Q_HALF 23'h000080
`define WT_RESET 8'h10

`endif

/* File: rtl/dct_cos_coef.v */
// Cosine coefficient table for an 8-point DCT, scaled by 64.
// Purely combinational; the caller supplies frequency and position.
`timescale 1ns/1ps
`default_nettype none
`include "dct_quant_rle_defines.vh"

module dct_cos_coef (
    input wire [2:0] freq,
    input wire [2:0] pos,
    output reg signed [7:0] coef
);

    wire [6:0] phase;
    reg [3:0] m;
    reg [6:0] mag;
    reg neg;

    // Angle index (2*pos+1)*freq, taken modulo 32
    assign phase = freq * {pos, 1'b1};

    always @*
    begin
        m = phase[3] ? (4'h0 - phase[3:0]) : phase[3:0];
        neg = phase[4] ^ (phase[3] & (phase[2:0] != 3'h0));
        case (m)
            4'h0: mag = `COS_K0;
            4'h1: mag = `COS_K1;
            4'h2: mag = `COS_K2;
            4'h3: mag = `COS_K3;
            4'h4: mag = `COS_K4;
            4'h5: mag = `COS_K5;
            4'h6: mag = `COS_K6;
            4'h7: mag = `COS_K7;
            default: mag = 7'h00;
        endcase
        if (freq == 3'h0)
        begin
            mag = `COS_DC;
            neg = 1'b0;
        end
        coef = neg ? (8'h00 - {1'b0, mag}) : {1'b0, mag};
    end

endmodule

`default_nettype wire

/* File: test/dct_quant_rle_encoder_chk.sv */
// Port checker for the residual coder.
// Bound to the coder; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dct_quant_rle_encoder_chk (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    input wire in_ready,
    input wire signed [8:0] in_sample,
    input wire in_intra,
    input wire out_valid,
    input wire out_ready,
    input wire [5:0] out_run,
    input wire signed [12:0] out_level,
    input wire block_end_marker,
    input wire out_intra
);
    reg [5:0] cnt_r;
    reg [7:0] pos_r;
    reg intra_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 6'h00;
            pos_r <= 8'h00;
            intra_r <= 1'b0;
        end
        else
        begin
            if (in_valid && in_ready)
                cnt_r <= cnt_r + 6'h01;
            if (in_valid && in_ready && cnt_r == 6'h00)
                intra_r <= in_intra;
            if (out_valid && out_ready)
                pos_r <= block_end_marker ? 8'h00 : pos_r + out_run + 8'h01;
        end
    end
    property p_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_run) && $stable(out_level)
            && $stable(block_end_marker) && $stable(out_intra);
    endproperty
    a_hold: assert property (p_hold) else $error("symbol changed while stalled");
    property p_zero;
        out_valid && block_end_marker |-> out_run == 6'h00 && out_level == 13'h0000;
    endproperty
    a_zero: assert property (p_zero) else $error("end marker with data");
    property p_nz;
        out_valid && !block_end_marker |-> out_level != 13'h0000;
    endproperty
    a_nz: assert property (p_nz) else $error("pair with zero level");
    property p_pos;
        out_valid && !block_end_marker |-> pos_r + out_run < 8'h40;
    endproperty
    a_pos: assert property (p_pos) else $error("scan past block end");
    property p_full;
        in_valid && in_ready && cnt_r == 6'h3F |=> !in_ready;
    endproperty
    a_full: assert property (p_full) else $error("ready after block");
    property p_quiet;
        in_ready |-> !out_valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("symbol during load");
    property p_back;
        out_valid && out_ready && block_end_marker |=> in_ready;
    endproperty
    a_back: assert property (p_back) else $error("no ready after marker");
    property p_intra;
        out_valid |-> out_intra == intra_r;
    endproperty
    a_intra: assert property (p_intra) else $error("wrong mode tag");
endmodule
`default_nettype wire

/* File: test/symbol_sink.sv */
// Downstream coder model: takes symbols, stalls every other cycle when slow.
// Stores up to eight symbols per block for the bench.
`timescale 1ns/1ps
`default_nettype none
module symbol_sink (
    input wire clk,
    input wire rst_n,
    input wire slow,
    input wire clr,
    input wire out_valid,
    input wire [5:0] out_run,
    input wire signed [12:0] out_level,
    input wire block_end_marker,
    input wire out_intra,
    output logic out_ready
);
    logic tag_a;
    logic [5:0] run_a [0:7];
    logic signed [12:0] lvl_a [0:7];
    logic mk_a [0:7];
    int num;
    logic tog;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_ready <= 1'b0;
            tog <= 1'b0;
            num <= 0;
        end
        else
        begin
            tog <= ~tog;
            out_ready <= ~slow | tog;
            if (clr)
                num <= 0;
            else if (out_valid && out_ready && num < 8)
            begin
                run_a[num] <= out_run;
                lvl_a[num] <= out_level;
                mk_a[num] <= block_end_marker;
                tag_a <= out_intra;
                num <= num + 1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/dct_quant_rle_encoder_bench.sv */
// Bench for the residual coder: flat and column-split blocks, weights, stalls.
// Uses the sink model downstream; checker bound below.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module dct_quant_rle_encoder_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic in_valid = 1'b0;
    logic signed [8:0] in_sample = 9'h000;
    logic in_intra = 1'b0;
    logic wt_wr = 1'b0;
    logic [5:0] wt_addr = 6'h00;
    logic [7:0] wt_data = 8'h00;
    logic slow = 1'b0;
    logic clr = 1'b0;
    wire in_ready, out_valid, out_ready, block_end_marker, out_intra;
    wire [5:0] out_run;
    wire signed [12:0] out_level;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    dct_quant_rle_encoder dut (.clk(clk), .rst_n(rst_n), .in_valid(in_valid),
        .in_ready(in_ready), .in_sample(in_sample), .in_intra(in_intra), .wt_wr(wt_wr),
        .wt_addr(wt_addr), .wt_data(wt_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_run(out_run), .out_level(out_level), .block_end_marker(block_end_marker),
        .out_intra(out_intra));
    symbol_sink sink (.clk(clk), .rst_n(rst_n), .slow(slow), .clr(clr),
        .out_valid(out_valid), .out_run(out_run), .out_level(out_level),
        .block_end_marker(block_end_marker), .out_intra(out_intra), .out_ready(out_ready));
    always #12.5 clk = ~clk;
    task complete_run;
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            num_errors++;
            complete_run;
        end
    end
    function automatic logic signed [12:0] exp_dc(input int s, input int w);
        int c;
        int p;
        c = (360 * s) >>> 7;
        c = (360 * c) >>> 7;
        p = c * w;
        exp_dc = (p < 0) ? -((-p + 128) >>> 8) : (p + 128) >>> 8;
    endfunction
    task wt_set(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        wt_wr <= 1'b1;
        wt_addr <= a;
        wt_data <= d;
        @(posedge clk);
        wt_wr <= 1'b0;
    endtask
    task run_block(input int split, input int amp, input logic intra, input logic sl);
        int i;
        @(posedge clk);
        clr <= 1'b1;
        slow <= sl;
        for (i = 0; i < 64; i++)
        begin
            in_valid <= 1'b1;
            in_intra <= intra;
            in_sample <= (split == 0 || i % 8 < 4) ? 9'(amp) : 9'(-amp);
            @(posedge clk);
            clr <= 1'b0;
            while (in_ready !== 1'b1)
                @(posedge clk);
        end
        in_valid <= 1'b0;
        i = 0;
        while (!(sink.num > 0 && sink.mk_a[sink.num - 1] === 1'b1) && i < 4000)
        begin
            @(posedge clk);
            i++;
        end
    endtask
    task t_dc(input int amp, input logic intra, input logic sl, input int w);
        run_block(0, amp, intra, sl);
        `CHK(sink.num, 2)
        `CHK(sink.run_a[0], 6'h00)
        `CHK(sink.lvl_a[0], exp_dc(amp, w))
        `CHK(sink.mk_a[1], 1'b1)
        `CHK(sink.tag_a, intra)
    endtask
    task t_zigzag;
        int i;
        for (i = 0; i < 64; i++)
            wt_set(i[5:0], 8'h00);
        wt_set(6'h01, 8'h10);
        wt_set(6'h03, 8'h10);
        run_block(1, 64, 1'b0, 1'b0);
        `CHK(sink.num, 3)
        `CHK(sink.run_a[0], 6'h01)
        `CHK(sink.run_a[1], 6'h04)
        `CHK(sink.lvl_a[0], 13'h001D)
        `CHK(sink.lvl_a[1], 13'h1FF6)
        `CHK(sink.mk_a[2], 1'b1)
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        `CHK(in_ready, 1'b1)
        `CHK(out_valid, 1'b0)
        rst_n <= 1'b1;
        t_dc(64, 1'b0, 1'b0, 16);
        t_dc(-100, 1'b1, 1'b1, 16);
        t_dc(-100, 1'b0, 1'b0, 16);
        wt_set(6'h00, 8'h00);
        run_block(0, 64, 1'b0, 1'b0);
        `CHK(sink.num, 1)
        wt_set(6'h00, 8'h20);
        t_dc(64, 1'b0, 1'b1, 32);
        t_dc(64, 1'b1, 1'b0, 32);
        t_zigzag;
        complete_run;
    end
endmodule
bind dct_quant_rle_encoder dct_quant_rle_encoder_chk chk (.clk(clk), .rst_n(rst_n),
    .in_valid(in_valid), .in_ready(in_ready), .in_sample(in_sample), .in_intra(in_intra),
    .out_valid(out_valid), .out_ready(out_ready), .out_run(out_run), .out_level(out_level),
    .block_end_marker(block_end_marker), .out_intra(out_intra));
`default_nettype wire
